// ===== core/tmi_pkg.sv
// tmi_pkg: shared constants and types for the three-axis interrupt merge block
// assumes: single 50 MHz clock domain, synchronous active-high reset
package tmi_pkg;

  localparam int unsigned N_AXES = 3;

  // -----------------------------------------------------------------
  // motion, status and auxiliary command codes on the command port
  // -----------------------------------------------------------------
  localparam logic [3:0] CMD_STOP        = 4'h1;
  localparam logic [3:0] CMD_JOG         = 4'h2;
  localparam logic [3:0] CMD_ACCEL_MOVE  = 4'h3;
  localparam logic [3:0] CMD_CONST_MOVE  = 4'h4;
  localparam logic [3:0] CMD_OUTER_LIMIT = 4'h5;
  localparam logic [3:0] CMD_INNER_LIMIT = 4'h6;
  localparam logic [3:0] CMD_REFERENCE   = 4'h7;
  localparam logic [3:0] CMD_READ_STATUS = 4'h8;
  localparam logic [3:0] CMD_TOGGLE_AUX  = 4'hD;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic RST_IRQ_EN  = 1'b0;
  localparam logic RST_AUX     = 1'b0;
  localparam logic RST_PENDING = 1'b0;

  typedef enum {AX_IDLE, AX_BUSY} tmi_axis_state_t;

  // decode of commands able to signal completion
  function automatic logic tmi_irq_capable(input logic [3:0] cmd);
    tmi_irq_capable = (cmd >= CMD_JOG) && (cmd <= CMD_REFERENCE);
  endfunction

endpackage

// ===== core/tmi_axis_if.sv
// tmi_axis_if: command and status bundle between top and one axis
// assumes: driven and sampled on the same clock as the top module
`timescale 1ns/10ps
interface tmi_axis_if;
  logic       cmd_valid;
  logic [3:0] cmd_code;
  logic       irq_en;
  logic       motion_done;
  logic       busy;
  logic       irq_req;
  logic       aux;
  logic       status_ok;
  logic       status_refused;

  modport top  (output cmd_valid, cmd_code, irq_en, motion_done,
                input  busy, irq_req, aux, status_ok, status_refused);
  modport axis (input  cmd_valid, cmd_code, irq_en, motion_done,
                output busy, irq_req, aux, status_ok, status_refused);
endinterface

// ===== core/tmi_axis.sv
// tmi_axis: completion-request and auxiliary-bit logic of one axis
// assumes: motion_done pulses once when the running motion command ends
`timescale 1ns/10ps
module tmi_axis
(
  input  wire logic clk,    // 50 MHz clock
  input  wire logic rst,    // synchronous reset
  tmi_axis_if.axis  ax      // command and status bundle
);

  typedef tmi_pkg::tmi_axis_state_t tmi_axis_state_t;

  typedef struct packed {
    tmi_axis_state_t st;
    logic            busy;
    logic            cmd_irq_en;
    logic            pending;
    logic            aux;
    logic            status_ok;
    logic            status_refused;
  } tmi_axis_reg_t;

  tmi_axis_reg_t s_r;
  tmi_axis_reg_t s_nxt;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    s_nxt                = s_r;
    s_nxt.status_ok      = 1'b0;
    s_nxt.status_refused = 1'b0;
    case (s_r.st)
      tmi_pkg::AX_IDLE:
      begin
        if (ax.cmd_valid)
        begin
          if (tmi_pkg::tmi_irq_capable(ax.cmd_code))
          begin
            s_nxt.st   = tmi_pkg::AX_BUSY;
            s_nxt.busy = 1'b1;
            s_nxt.cmd_irq_en = ax.irq_en;
          end
          else if (ax.cmd_code == tmi_pkg::CMD_READ_STATUS)
          begin
            s_nxt.pending   = 1'b0;
            s_nxt.status_ok = 1'b1;
          end
          else if (ax.cmd_code == tmi_pkg::CMD_TOGGLE_AUX)
          begin
            s_nxt.aux = ~s_r.aux;
          end
        end
      end
      tmi_pkg::AX_BUSY:
      begin
        if (ax.cmd_valid && ax.cmd_code == tmi_pkg::CMD_READ_STATUS)
        begin
          s_nxt.status_refused = 1'b1;
        end
        if (ax.motion_done)
        begin
          s_nxt.st   = tmi_pkg::AX_IDLE;
          s_nxt.busy = 1'b0;
          if (s_r.cmd_irq_en)
          begin
            s_nxt.pending = 1'b1;
          end
        end
      end
      default:
      begin
        s_nxt.st = tmi_pkg::AX_IDLE;
      end
    endcase
    if (rst)
    begin
      s_nxt.st             = tmi_pkg::AX_IDLE;
      s_nxt.busy           = 1'b0;
      s_nxt.cmd_irq_en     = tmi_pkg::RST_IRQ_EN;
      s_nxt.pending        = tmi_pkg::RST_PENDING;
      s_nxt.aux            = tmi_pkg::RST_AUX;
      s_nxt.status_ok      = 1'b0;
      s_nxt.status_refused = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  assign ax.busy           = s_r.busy;
  assign ax.irq_req        = s_r.pending;
  assign ax.aux            = s_r.aux;
  assign ax.status_ok      = s_r.status_ok;
  assign ax.status_refused = s_r.status_refused;

endmodule

// ===== core/tmi_merge.sv
// tmi_merge: three-axis completion interrupt merge with jumper-routed output
//
// Contract
// - axis requests interrupt on qualifying completion
// - only jog and five move commands qualify
// - enable change applies from next command
// - output high impedance while interrupts disabled
// - interrupts disabled after reset and initialization
// - three axis requests ORed together
// - finish status read clears axis request
// - output routed to jumpered level 2..7
// - toggle command inverts axis auxiliary bit; the axis ignores it while busy
// - status read refused while motor busy
//
// assumes: command port and jumper are synchronous to clk except where
// noted; the motion engine pulses motion_done per axis
`timescale 1ns/10ps
module tmi_merge
(
  input  wire logic       clk,            // 50 MHz clock
  input  wire logic       rst,            // synchronous reset
  input  wire logic       cmd_valid,      // one-cycle command strobe
  input  wire logic [1:0] cmd_axis,       // axis 0..2
  input  wire logic [3:0] cmd_code,       // command code
  input  wire logic       init,           // one-cycle initialization strobe
  input  wire logic       irq_set,        // one-cycle enable/disable strobe
  input  wire logic       irq_set_val,    // 1 enable, 0 disable
  input  wire logic [2:0] motion_done,    // per-axis end of motion pulses
  input  wire logic [2:0] irq_jumper,     // level jumper 2..7, from a pin
  output logic      [5:0] irq_o,          // levels 2..7, bit 0 is level 2
  output logic      [5:0] irq_oe_n,       // low = driving that level
  output logic      [2:0] aux_o,          // auxiliary bits
  output logic      [2:0] busy_o,         // axis motor busy
  output logic      [2:0] pending_o,      // axis pending request
  output logic            status_ok_o,    // status read accepted
  output logic            status_busy_o   // status read refused
);

  typedef struct packed {
    logic [2:0] irq_en;
    logic [2:0] jmp_meta;
    logic [2:0] jmp_sync;
    logic [5:0] irq;
    logic [5:0] oe_n;
    logic [2:0] aux;
    logic [2:0] busy;
    logic [2:0] pending;
    logic       st_ok;
    logic       st_busy;
  } tmi_top_reg_t;

  tmi_top_reg_t s_r;
  tmi_top_reg_t s_nxt;

  logic [2:0] ax_busy;
  logic [2:0] ax_req;
  logic [2:0] ax_aux;
  logic [2:0] ax_ok;
  logic [2:0] ax_ref;

  // -----------------------------------------------------------------
  // axis instances
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < tmi_pkg::N_AXES; g++)
    begin : gen_axis
      tmi_axis_if ax ();
      assign ax.cmd_valid   = cmd_valid && (cmd_axis == 2'(g));
      assign ax.cmd_code    = cmd_code;
      assign ax.irq_en      = s_r.irq_en[g];
      assign ax.motion_done = motion_done[g];
      assign ax_busy[g]     = ax.busy;
      assign ax_req[g]      = ax.irq_req;
      assign ax_aux[g]      = ax.aux;
      assign ax_ok[g]       = ax.status_ok;
      assign ax_ref[g]      = ax.status_refused;
      tmi_axis u_axis
      (
        .clk (clk),
        .rst (rst),
        .ax  (ax)
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // enables, jumper sync, output routing
  // -----------------------------------------------------------------
  always_comb
  begin
    logic any_en;
    logic merged;
    any_en  = 1'b0;
    merged  = 1'b0;
    s_nxt   = s_r;
    s_nxt.jmp_meta = irq_jumper;
    s_nxt.jmp_sync = s_r.jmp_meta;
    if (init && cmd_axis < 2'(tmi_pkg::N_AXES))
    begin
      s_nxt.irq_en[cmd_axis] = 1'b0;
    end
    else if (irq_set && cmd_axis < 2'(tmi_pkg::N_AXES))
    begin
      s_nxt.irq_en[cmd_axis] = irq_set_val;
    end
    any_en = |s_r.irq_en;
    merged = |ax_req;
    s_nxt.irq  = 6'h00;
    s_nxt.oe_n = 6'h3F;
    if (any_en && s_r.jmp_sync >= 3'h2 && s_r.jmp_sync <= 3'h7)
    begin
      s_nxt.irq[s_r.jmp_sync - 3'h2]  = merged;
      s_nxt.oe_n[s_r.jmp_sync - 3'h2] = 1'b0;
    end
    s_nxt.aux     = ax_aux;
    s_nxt.busy    = ax_busy;
    s_nxt.pending = ax_req;
    s_nxt.st_ok   = |ax_ok;
    s_nxt.st_busy = |ax_ref;
    if (rst)
    begin
      s_nxt = '0;
      s_nxt.oe_n = 6'h3F;
    end
  end

  always_ff @(posedge clk)
  begin
    s_r <= s_nxt;
  end

  assign irq_o         = s_r.irq;
  assign irq_oe_n      = s_r.oe_n;
  assign aux_o         = s_r.aux;
  assign busy_o        = s_r.busy;
  assign pending_o     = s_r.pending;
  assign status_ok_o   = s_r.st_ok;
  assign status_busy_o = s_r.st_busy;

endmodule

// ===== testbench/tmi_host_model.sv
// host bus side of the six interrupt levels
// assumes: bit 0 is level 2, lines pulled up on the host bus
`timescale 1ns/10ps
module tmi_host_model
(
  input  wire logic [5:0] irq_o,    // board drive value
  input  wire logic [5:0] irq_oe_n, // low while board drives
  output wire logic [5:0] line      // level seen by host
);
  assign line = irq_o | irq_oe_n;
endmodule

// ===== testbench/tmi_merge_properties.sv
// port assertions of the interrupt merge
// assumes: bound onto tmi_merge, one clock
`timescale 1ns/10ps
module tmi_merge_properties
(
  input wire logic       clk,          // clock
  input wire logic       rst,          // reset
  input wire logic       cmd_valid,    // strobe
  input wire logic [1:0] cmd_axis,     // axis
  input wire logic [3:0] cmd_code,     // code
  input wire logic       init,         // init
  input wire logic       irq_set,      // enable strobe
  input wire logic       irq_set_val,  // enable value
  input wire logic [2:0] motion_done,  // ends
  input wire logic [2:0] irq_jumper,   // jumper
  input wire logic [5:0] irq_o,        // levels
  input wire logic [5:0] irq_oe_n,     // drives
  input wire logic [2:0] aux_o,        // aux
  input wire logic [2:0] busy_o,       // busy
  input wire logic [2:0] pending_o,    // requests
  input wire logic       status_ok_o,  // read done
  input wire logic       status_busy_o // read refused
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_RST: assert property (
    $past(rst) |-> irq_oe_n == 6'h3F && pending_o == 3'h0 && aux_o == 3'h0)
    else $error("reset state wrong");
  // jumper settles through a synchronizer, so only a steady jumper is judged
  AST_LVL: assert property (
    irq_oe_n != 6'h3F && $stable(irq_jumper) && $past(irq_jumper, 4) == irq_jumper
    |-> ~irq_oe_n == (6'h01 << (irq_jumper - 3'h2))) else $error("wrong level");
  AST_OR: assert property (
    irq_oe_n != 6'h3F |-> (|(irq_o & ~irq_oe_n)) == (|pending_o))
    else $error("level not OR of requests");
  AST_SET: assert property (
    |(pending_o & ~$past(pending_o)) |-> |$past(motion_done, 2))
    else $error("request without completion");
  AST_HOLD: assert property (
    !$past(rst) && |($past(pending_o) & ~pending_o) |-> status_ok_o)
    else $error("request dropped");
  AST_CLR: assert property (
    status_ok_o |-> !pending_o[$past(cmd_axis, 2)]) else $error("read left request");
  AST_STAT: assert property (
    status_ok_o || status_busy_o |-> !(status_ok_o && status_busy_o) && $past(cmd_valid, 2)
    && $past(cmd_code, 2) == tmi_pkg::CMD_READ_STATUS) else $error("stray status");
  AST_AUX: assert property (
    !$past(rst) && aux_o != $past(aux_o) |-> $onehot(aux_o ^ $past(aux_o))
    && $past(cmd_code, 2) == tmi_pkg::CMD_TOGGLE_AUX) else $error("stray aux change");
  COV_REFUSED: cover property (status_busy_o);
  COV_CLEARED: cover property (status_ok_o && irq_oe_n != 6'h3F);
  COV_AUX: cover property (aux_o != $past(aux_o));
endmodule
bind tmi_merge tmi_merge_properties tmi_merge_properties_inst (.clk, .rst, .cmd_valid,
  .cmd_axis, .cmd_code, .init, .irq_set, .irq_set_val, .motion_done, .irq_jumper, .irq_o,
  .irq_oe_n, .aux_o, .busy_o, .pending_o, .status_ok_o, .status_busy_o);

// ===== testbench/tb.sv
// self-checking bench of the interrupt merge
// assumes: host model and checker compiled before it
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic       clk = 0, rst = 1, cmd_valid = 0, init = 0, irq_set = 0, irq_set_val = 0;
  logic [1:0] cmd_axis = 0, note, ax, notes[$];
  logic [3:0] cmd_code = 0;
  logic [2:0] motion_done = 0, irq_jumper = 3'h2, aux_o, busy_o, pending_o, exp_aux = 0;
  logic [5:0] irq_o, irq_oe_n, line;
  logic       status_ok_o, status_busy_o;
  logic [31:0] seed = 84;
  int         failures = 0, checked = 0, cycles = 0;
  always #10 clk = ~clk;
  tmi_merge tmi_merge_inst (.clk, .rst, .cmd_valid, .cmd_axis, .cmd_code, .init, .irq_set,
    .irq_set_val, .motion_done, .irq_jumper, .irq_o, .irq_oe_n, .aux_o, .busy_o,
    .pending_o, .status_ok_o, .status_busy_o);
  tmi_host_model tmi_host_model_inst (.irq_o, .irq_oe_n, .line);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmd(input logic [1:0] a, input logic [3:0] c);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_axis <= a;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 1'h0;
  endtask
  task automatic en(input logic [1:0] a, input logic v);
    @(posedge clk);
    irq_set <= 1'h1;
    cmd_axis <= a;
    irq_set_val <= v;
    @(posedge clk);
    irq_set <= 1'h0;
  endtask
  task automatic dn(input logic [1:0] a);
    @(posedge clk);
    motion_done <= 3'h1 << a;
    @(posedge clk);
    motion_done <= 3'h0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [1:0] e);
    notes.push_back(e);
    cmd(a, tmi_pkg::CMD_READ_STATUS);
    cyc(3);
  endtask
  task automatic stop_test();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      stop_test();
    end
    if (!rst && (status_ok_o || status_busy_o))
    begin
      note = (notes.size() == 0) ? 2'h3 : notes.pop_front();
      `CHK({status_busy_o, status_ok_o}, note)
    end
  end
  initial
  begin
    cyc(6);
    rst <= 1'h0;
    cyc(4);
    `CHK(irq_oe_n, 6'h3F)
    for (int j = 2; j <= 7; j++)
    begin
      ax = 2'(j % 3);
      irq_jumper <= 3'(j);
      en(ax, 1'h1);
      cyc(5);
      `CHK(line, ~(6'h01 << (j - 2)))
      cmd(ax, 4'(j));
      cyc(2);
      `CHK(busy_o, 3'h1 << ax)
      dn(ax);
      cyc(3);
      `CHK(line, 6'h3F)
      rd(ax, 2'h1);
      `CHK(line, ~(6'h01 << (j - 2)))
      en(ax, 1'h0);
      cyc(2);
      `CHK(irq_oe_n, 6'h3F)
    end
    cmd(2'h0, tmi_pkg::CMD_ACCEL_MOVE);
    en(2'h0, 1'h1);
    dn(2'h0);
    cyc(3);
    `CHK(pending_o, 3'h0)
    cmd(2'h0, tmi_pkg::CMD_CONST_MOVE);
    rd(2'h0, 2'h2);
    dn(2'h0);
    cyc(8);
    `CHK(pending_o, 3'h1)
    rd(2'h0, 2'h1);
    `CHK(pending_o, 3'h0)
    @(posedge clk);
    init <= 1'h1;
    cmd_axis <= 2'h0;
    @(posedge clk);
    init <= 1'h0;
    cyc(2);
    `CHK(irq_oe_n, 6'h3F)
    repeat (6)
    begin
      ax = 2'(rnd() % 3);
      exp_aux ^= 3'h1 << ax;
      cmd(ax, tmi_pkg::CMD_TOGGLE_AUX);
      cyc(3);
      `CHK(aux_o, exp_aux)
    end
    cyc(2);
    `CHK(notes.size(), 0)
    stop_test();
  end
endmodule
